//--- design/ebt_event_timer.sv
// Purpose: 8-bit timer / event counter with AHB-Lite registers
// Assumes: One word per register, single word transfers only
// Notes:   INST_B picks the second instance's clock table
//
// Overview of operation
// [RL1] 8-bit read-only counter steps per count clock
// [RL2] Counter clears on reset, stop, match in clear mode
// [RL3] Non-PWM: equality raises the timer interrupt
// [RL4] PWM: overflow activates output, match deactivates
// [RL5] Compare register full range, resets zero
// [RL6] Software keeps compare fixed in clear mode
// [RL7] Software spaces PWM compare writes three clocks
// [RL8] Clock select codes for first instance
// [RL9] Second instance: fx/16 and fx/4096 codes
// [RL10] Clock select byte write, resets to zero
// [RL11] Software stops timer before clock reselect
// [RL12] Software writes zero to upper five bits
// [RL13] Enable bit zero stops and clears counter
// [RL14] Mode bit picks clear mode or PWM
// [RL15] Output enable zero holds pin low
// [RL16] Level bit: toggle enable or PWM polarity
// [RL17] External input synchronised, edge detected
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module ebt_event_timer
  import ebt_pkg::*;
#(
  parameter logic INST_B = 1'b0
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Timer pins
  input  wire logic        eventInputPin,
  output logic             timerOutputPin,
  // Interrupt
  output logic             matchInterrupt
);
  // Clock select byte address for this instance
  localparam logic [15:0] IDX_CS =
    INST_B ? IDX_CLKSEL_B : IDX_CLKSEL_A;
  localparam logic [31:0] OFS_CLKSEL =
    {14'h0000, IDX_CS, 2'h0};

  // Whole state of the block
  typedef struct packed {
    ebt_bus_type      bst;    // Bus phase
    logic             wr;     // Latched write flag
    logic [31:0]      addr;   // Latched address
    logic             rdy;    // Hready out
    logic [31:0]      rdata;  // Read data
    logic [7:0]       cnt;    // Event counter
    logic [7:0]       match;  // Match value
    logic [7:0]       mode;   // Timer mode control
    logic [7:0]       clksel; // Count clock select
    logic [ST_W-1:0]  stat;   // Sticky events
    logic [ST_W-1:0]  mask;   // Interrupt mask
    logic             toff;   // Timer output flip-flop
    logic             pwmff;  // PWM flip-flop
    logic             pin;    // Timer output pin
    logic             irq;    // Interrupt line
  } ebt_state_type;

  // Reset picture of the state
  localparam ebt_state_type RST_STATE = '{
    bst:    BUS_IDLE,
    wr:     1'b0,
    addr:   32'h0000_0000,
    rdy:    1'b1,
    rdata:  32'h0000_0000,
    cnt:    RST_BYTE,
    match:  RST_BYTE,
    mode:   RST_BYTE,
    clksel: RST_BYTE,
    stat:   '0,
    mask:   '0,
    toff:   1'b0,
    pwmff:  1'b0,
    pin:    1'b0,
    irq:    1'b0
  };

  ebt_state_type     s;
  ebt_state_type     next_s;
  logic [PRE_W:0]    preTick;  // Prescaler taps
  logic              evRise;   // Input rising edge
  logic              evFall;   // Input falling edge
  logic              tick;     // Selected count clock
  logic              run;      // Count enable
  logic              pwm;      // PWM mode
  logic              eq;       // Counter equals match
  logic              wrNow;    // Write lands this cycle
  logic              accept;   // Address phase taken
  logic              matchEv;  // Clear-mode match event
  logic              ovfEv;    // Counter wrap event
  logic              clrStat;  // Status read clears
  logic [31:0]       rdVal;    // Read mux output
  logic [ST_W-1:0]   events;   // Event bits for status

  // Divider of the main oscillator clock
  ebt_prescaler #(
    .W (PRE_W)
  ) u_pre (
    .core_clk (core_clk),
    .reset    (reset),
    .tick     (preTick)
  );

  // Event input edges, two flops deep
  ebt_edge_sync u_edge (
    .core_clk (core_clk),
    .reset    (reset),
    .pinIn    (eventInputPin),
    .rise     (evRise),
    .fall     (evFall)
  );

  assign run = s.mode[MB_EN];
  assign pwm = s.mode[MB_PWM];
  assign eq  = (s.cnt == s.match);
  assign accept = hsel & htrans[1] & hready;
  assign wrNow  = (s.bst == BUS_HOLD) & s.wr;

  // Count clock source; upper select bits ignored
  always_comb begin
    case (s.clksel[2:0])
      CS_FALL: tick = evFall;                       // [RL17]
      CS_RISE: tick = evRise;                       // [RL17]
      CS_FX:   tick = preTick[0];                   // [RL8]
      CS_FX2:  tick = preTick[LOG_FX2];             // [RL8]
      CS_MID:  tick = INST_B ? preTick[LOG_B_MID]   // [RL9]
                             : preTick[LOG_A_MID];  // [RL8]
      CS_64:   tick = preTick[LOG_64];              // [RL8]
      CS_256:  tick = preTick[LOG_256];             // [RL8]
      CS_SLOW: tick = INST_B ? preTick[LOG_B_SLOW]  // [RL9]
                             : preTick[LOG_A_SLOW]; // [RL8]
      default: tick = 1'b0;
    endcase
  end

  // Read mux; unmapped words read zero
  always_comb begin
    rdVal = 32'h0000_0000;
    case (s.addr)
      OFS_COUNT:  rdVal = {24'h000000, s.cnt};
      OFS_MATCH:  rdVal = {24'h000000, s.match};
      OFS_MODE:   rdVal = {24'h000000, s.mode};
      OFS_STATUS: rdVal = {{(32-ST_W){1'b0}}, s.stat};
      OFS_MASK:   rdVal = {{(32-ST_W){1'b0}}, s.mask};
      OFS_CLKSEL: rdVal = {24'h000000, s.clksel};
      default:    rdVal = 32'h0000_0000;
    endcase
  end

  // Next state of bus, counter, output and interrupt
  always_comb begin
    next_s  = s;
    matchEv = 1'b0;
    ovfEv   = 1'b0;
    clrStat = 1'b0;
    // Counter: stop clears, match clears in clear mode
    if (!run) begin
      next_s.cnt   = RST_BYTE;                      // [RL13] [RL2]
      next_s.pwmff = 1'b0;
    end else if (tick) begin
      if (!pwm && eq) begin
        next_s.cnt = RST_BYTE;                      // [RL2] [RL14]
        matchEv    = 1'b1;                          // [RL3]
      end else begin
        next_s.cnt = s.cnt + 8'h01;                 // [RL1]
        ovfEv      = (s.cnt == CNT_TOP);
      end
    end
    // PWM flip-flop: match drops it, overflow wins
    if (run && pwm && eq) begin
      next_s.pwmff = 1'b0;                          // [RL4]
    end
    if (run && pwm && ovfEv) begin
      next_s.pwmff = 1'b1;                          // [RL4]
    end
    // Timer flip-flop toggles on match if enabled
    if (matchEv && s.mode[MB_LVL]) begin
      next_s.toff = ~s.toff;                        // [RL16]
    end
    // Bus phases: one wait cycle, then data
    next_s.rdy = 1'b1;
    case (s.bst)
      BUS_IDLE, BUS_ANSW: begin
        if (accept) begin
          next_s.bst  = BUS_HOLD;
          next_s.wr   = hwrite;
          next_s.addr = haddr;
          next_s.rdy  = 1'b0;
        end else begin
          next_s.bst = BUS_IDLE;
        end
      end
      BUS_HOLD: begin
        next_s.bst = BUS_ANSW;
        if (s.wr) begin
          case (s.addr)
            OFS_MATCH: begin
              next_s.match = hwdata[7:0];           // [RL5]
            end
            OFS_MODE: begin
              next_s.mode = hwdata[7:0] & MODE_KEEP;
              // Set/reset strobes act outside PWM only
              if (!hwdata[MB_PWM] &&
                  hwdata[MB_SET] && !hwdata[MB_CLR]) begin
                next_s.toff = 1'b1;
              end else if (!hwdata[MB_PWM] &&
                  !hwdata[MB_SET] && hwdata[MB_CLR]) begin
                next_s.toff = 1'b0;
              end
            end
            OFS_MASK: begin
              next_s.mask = hwdata[ST_W-1:0];
            end
            OFS_CLKSEL: begin
              next_s.clksel = hwdata[7:0];          // [RL10]
            end
            default: begin
              next_s.wr = 1'b0;  // Counter and unmapped ignore
            end
          endcase
        end else begin
          next_s.rdata = rdVal;
          clrStat      = (s.addr == OFS_STATUS);
        end
      end
      default: begin
        next_s.bst = BUS_IDLE;
      end
    endcase
    // Sticky status: an event beats a read clear
    events           = '0;
    events[ST_MATCH] = matchEv;
    events[ST_OVF]   = ovfEv;
    next_s.stat = (clrStat ? '0 : s.stat) | events;
    next_s.irq  = |(next_s.stat & next_s.mask);     // [RL3]
    // Pin low while output disabled
    if (!next_s.mode[MB_OE]) begin
      next_s.pin = 1'b0;                            // [RL15]
    end else if (next_s.mode[MB_PWM]) begin
      next_s.pin = next_s.pwmff ^ next_s.mode[MB_LVL]; // [RL16]
    end else begin
      next_s.pin = next_s.toff;
    end
  end

  // State register
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s <= RST_STATE;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from flops, hresp tied low
  assign hreadyout      = s.rdy;
  assign hresp          = 1'b0;
  assign hrdata         = s.rdata;
  assign timerOutputPin = s.pin;
  assign matchInterrupt = s.irq;

  // Checks on the block's own behaviour
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  AST_CNT_STEP: assert property ( // [RL1]
    run && tick && !(!pwm && eq) && !wrNow
    |=> s.cnt == $past(s.cnt) + 8'h01)
    else $error("counter did not step on count clock");

  AST_CNT_STOP: assert property ( // [RL13]
    !run ##1 !run |-> s.cnt == RST_BYTE && !s.pwmff)
    else $error("stopped counter not cleared");

  AST_MATCH_CLR: assert property ( // [RL2]
    run && !pwm && tick && eq
    |=> s.cnt == RST_BYTE && s.stat[ST_MATCH])
    else $error("match did not clear counter and flag");

  AST_IRQ_LEVEL: assert property ( // [RL3]
    s.irq == |(s.stat & s.mask))
    else $error("interrupt line disagrees with status");

  AST_PWM_ON: assert property ( // [RL4]
    run && pwm && tick && s.cnt == CNT_TOP && !wrNow
    && s.mode[MB_OE] && !s.mode[MB_LVL]
    |=> timerOutputPin)
    else $error("overflow did not activate output");

  AST_PWM_OFF: assert property ( // [RL4]
    run && pwm && eq && !(tick && s.cnt == CNT_TOP)
    && !wrNow && s.mode[MB_OE] && !s.mode[MB_LVL]
    |=> !timerOutputPin)
    else $error("match did not deactivate output");

  AST_MATCH_HOLD: assert property ( // [RL5]
    !wrNow |=> s.match == $past(s.match))
    else $error("match value changed without write");

  AST_OE_LOW: assert property ( // [RL15]
    !s.mode[MB_OE] |-> !timerOutputPin)
    else $error("pin driven while output disabled");

  AST_TOGGLE: assert property ( // [RL16]
    run && !pwm && tick && eq && s.mode[MB_LVL]
    && s.mode[MB_OE] && !wrNow
    |=> timerOutputPin != $past(timerOutputPin))
    else $error("output did not toggle on match");

  AST_SRC_FX: assert property ( // [RL8]
    s.clksel[2:0] == CS_FX |-> tick)
    else $error("fx source did not tick every cycle");

  AST_EDGE_SRC: assert property ( // [RL17]
    s.clksel[2:0] == CS_RISE |-> tick == evRise)
    else $error("rising edge source mis-selected");

  AST_OVF_FLAG: assert property ( // [RL4]
    ovfEv |=> s.stat[ST_OVF])
    else $error("overflow did not set status");

  AST_BUS_WAIT: assert property (
    accept && s.bst != BUS_HOLD |=> !hreadyout ##1 hreadyout)
    else $error("bus answer not after one wait cycle");
endmodule // ebt_event_timer
`default_nettype wire

//--- include/ebt_pkg.sv
// Purpose: Shared constants and types of the 8-bit event timer
// Assumes: One 32-bit AHB-Lite slave port, word registers
// Notes:   Clock select sits at four times its index
package ebt_pkg;
  // Byte addresses of the word registers
  localparam logic [31:0] OFS_COUNT    = 32'h0000_0000;
  localparam logic [31:0] OFS_MATCH    = 32'h0000_0004;
  localparam logic [31:0] OFS_MODE     = 32'h0000_0008;
  localparam logic [31:0] OFS_STATUS   = 32'h0000_000C;
  localparam logic [31:0] OFS_MASK     = 32'h0000_0010;
  // Clock select indexes, byte address is index times four
  localparam logic [15:0] IDX_CLKSEL_A = 16'hFF6A;
  localparam logic [15:0] IDX_CLKSEL_B = 16'hFF8C;
  // Reset value, mode keep mask and counter top
  localparam logic [7:0]  RST_BYTE     = 8'h00;
  localparam logic [7:0]  MODE_KEEP    = 8'hC3;
  localparam logic [7:0]  CNT_TOP      = 8'hFF;
  // Mode control bit positions
  localparam int MB_EN  = 7;
  localparam int MB_PWM = 6;
  localparam int MB_SET = 3;
  localparam int MB_CLR = 2;
  localparam int MB_LVL = 1;
  localparam int MB_OE  = 0;
  // Status and mask bit positions
  localparam int ST_W     = 2;
  localparam int ST_MATCH = 0;
  localparam int ST_OVF   = 1;
  // Count clock select codes
  localparam logic [2:0] CS_FALL = 3'h0;
  localparam logic [2:0] CS_RISE = 3'h1;
  localparam logic [2:0] CS_FX   = 3'h2;
  localparam logic [2:0] CS_FX2  = 3'h3;
  localparam logic [2:0] CS_MID  = 3'h4;
  localparam logic [2:0] CS_64   = 3'h5;
  localparam logic [2:0] CS_256  = 3'h6;
  localparam logic [2:0] CS_SLOW = 3'h7;
  // Prescaler depth and tap positions (log2 of divisor)
  localparam int PRE_W      = 13;
  localparam int LOG_FX2    = 1;
  localparam int LOG_A_MID  = 2;
  localparam int LOG_B_MID  = 4;
  localparam int LOG_64     = 6;
  localparam int LOG_256    = 8;
  localparam int LOG_A_SLOW = 13;
  localparam int LOG_B_SLOW = 12;
  // Bus slave phases, Gray coded
  typedef enum logic [1:0] {
    BUS_IDLE = 2'h0,
    BUS_HOLD = 2'h1,
    BUS_ANSW = 2'h3
  } ebt_bus_type;
endpackage

//--- design/ebt_prescaler.sv
// Purpose: Free-running divider of the main oscillator clock
// Assumes: Taps are one-cycle pulses every 2**k cycles
// Notes:   Tap 0 is high every cycle
`timescale 1ns/1ps
`default_nettype none
module ebt_prescaler
  import ebt_pkg::*;
#(
  parameter int W = PRE_W
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         reset,
  // Divided ticks
  output logic [W:0]        tick
);
  // Whole state of the divider
  typedef struct packed {
    logic [W-1:0] cnt;
    logic [W:0]   tick;
  } ebt_pre_type;

  ebt_pre_type s;
  ebt_pre_type next_s;
  logic [W:0]  allOnes;

  // One tap per stage: low k bits all ones
  assign allOnes[0] = 1'b1;
  for (genvar k = 1; k <= W; k++) begin : g_tap
    assign allOnes[k] = &s.cnt[k-1:0];
  end

  // Next divider state
  always_comb begin
    next_s      = s;
    next_s.cnt  = s.cnt + {{(W-1){1'b0}}, 1'b1};
    next_s.tick = allOnes;
  end

  // State register
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;
endmodule // ebt_prescaler
`default_nettype wire

//--- design/ebt_edge_sync.sv
// Purpose: Synchroniser and edge detector for the event input
// Assumes: Input pulses last more than two clock cycles
// Notes:   Edges come out two to three cycles late
`timescale 1ns/1ps
`default_nettype none
module ebt_edge_sync (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic reset,
  // Raw pin and detected edges
  input  wire logic pinIn,
  output logic      rise,
  output logic      fall
);
  // Whole state of the detector
  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
    logic rise;
    logic fall;
  } ebt_edge_type;

  ebt_edge_type s;
  ebt_edge_type next_s;

  // Only the second stage looks at the first
  always_comb begin
    next_s      = s;
    next_s.meta = pinIn;
    next_s.sync = s.meta;
    next_s.prev = s.sync;
    next_s.rise = s.sync & ~s.prev;
    next_s.fall = ~s.sync & s.prev;
  end

  // State register
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rise = s.rise;
  assign fall = s.fall;
endmodule // ebt_edge_sync
`default_nettype wire

//--- dv/ebt_pin_model.sv
// Purpose: Far-side model driving the external event input pin
// Assumes: Pin idles low, each level held several clock cycles
// Notes:   Pulses are started by the bench through task pulse
`timescale 1ns/1ps
`default_nettype none
module ebt_pin_model (
  // Clock
  input  wire logic core_clk,
  // Event pin
  output logic      eventInputPin
);
  // Idle low from time zero so no stray edge is seen
  initial begin
    eventInputPin = 1'b0;
  end
  // Each level lasts four cycles, longer than the synchroniser needs
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge core_clk);
      eventInputPin <= 1'b1;
      repeat (4) @(posedge core_clk);
      eventInputPin <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
  endtask
endmodule // ebt_pin_model
`default_nettype wire

//--- dv/eight_bit_event_timer_bench.sv
// Purpose: Self-checking bench of the 8-bit event timer
// Assumes: Both instance clock tables, one wait cycle bus slave
// Notes:   Register image is kept in an integer model
`timescale 1ns/1ps
`default_nettype none
module eight_bit_event_timer_bench
  import ebt_pkg::*;
;
  // Clock select byte address
  localparam logic [31:0] CSA = {14'h0, IDX_CLKSEL_A, 2'h0};
  localparam logic [31:0] CSB = {14'h0, IDX_CLKSEL_B, 2'h0};
  // Bus and pins
  logic        core_clk, reset, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        eventInputPin, timerOutputPin, matchInterrupt;
  // Second instance and the mux that picks the addressed one
  logic        selB, hreadyoutB, hrespB, timerOutputPinB, rdy, resp, tpin;
  logic [31:0] hrdataB, rdat;
  // Counters and scratch
  int          failures, check_count, c, m, n;
  int          mdl [logic [31:0]];
  int          lg [8] = '{0, 0, 0, LOG_FX2, LOG_A_MID, LOG_64, LOG_256,
                          LOG_A_SLOW};
  logic [31:0] regs [7] = '{OFS_COUNT, OFS_MATCH, OFS_MODE, OFS_STATUS,
                            OFS_MASK, CSA, 32'h0000_0020};
  // Device under test, hready fed back from the addressed instance's ready
  ebt_event_timer #(.INST_B(1'b0)) i_dut (
    .core_clk(core_clk), .reset(reset), .hsel(hsel & ~selB), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(rdy), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .eventInputPin(eventInputPin),
    .timerOutputPin(timerOutputPin), .matchInterrupt(matchInterrupt));
  // Second instance, own clock table, selected by selB
  ebt_event_timer #(.INST_B(1'b1)) i_dut_b (
    .core_clk(core_clk), .reset(reset), .hsel(hsel & selB), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(rdy), .hreadyout(hreadyoutB), .hresp(hrespB),
    .hrdata(hrdataB), .eventInputPin(eventInputPin),
    .timerOutputPin(timerOutputPinB), .matchInterrupt());
  // Bus answer and watched pin of the addressed instance
  assign rdy  = selB ? hreadyoutB : hreadyout;
  assign resp = selB ? hrespB : hresp;
  assign rdat = selB ? hrdataB : hrdata;
  assign tpin = selB ? timerOutputPinB : timerOutputPin;
  // Far side of the event pin
  ebt_pin_model i_pin (.core_clk(core_clk), .eventInputPin(eventInputPin));
  // Free-running 250 MHz clock
  always #2 core_clk = ~core_clk;
  // Compare of register words and counts
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Compare of single pin levels
  task automatic chkb(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: pin %b want %b", $time, got, exp);
    end
  endtask
  // One single AHB-Lite transfer; the bound only guards a hang
  task automatic bus(input logic [31:0] a, input logic w,
                     input logic [31:0] d);
    int k;
    k = 0;
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do begin
      @(posedge core_clk);
      k++;
    end while (rdy !== 1'b1 && k < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge core_clk);
      k++;
    end while (rdy !== 1'b1 && k < 50);
    rd = rdat;
    chkb(resp, 1'b0); // Response is always OKAY
    if (k >= 50) begin
      failures++;
      $display("unexpected at %0t: bus hang", $time);
    end
  endtask
  // Write and update the model image with the readable bits
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
    case (a)
      OFS_MATCH: mdl[a] = int'(d & 32'hFF);
      OFS_MODE:  mdl[a] = int'(d & 32'hC3); // Strobes read back zero
      OFS_MASK:  mdl[a] = int'(d & 32'h03);
      CSA:       mdl[a] = int'(d & 32'hFF);
      default: ;                            // Read-only or unmapped
    endcase
  endtask
  // Read and compare with the model image
  task automatic rdc(input logic [31:0] a);
    bus(a, 1'b0, 32'h0);
    chk(rd, 32'(mdl[a]));
  endtask
  // Cycles between two output changes
  task automatic gap(output int g);
    logic p;
    p = tpin;
    g = 0;
    do begin
      @(posedge core_clk);
      g++;
    end while (tpin === p && g < 40000);
  endtask
  // High cycles in one 256-cycle window
  task automatic hi(output int h);
    h = 0;
    repeat (256) begin
      @(posedge core_clk);
      if (timerOutputPin === 1'b1) h++;
    end
  endtask
  task automatic done(input string s);
    $display("test %s done, failures %0d", s, failures);
  endtask
  // Verdict and end of run
  task automatic stop_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Watchdog at 75k cycles, well past the at most 30k expected
  initial begin
    #300000;
    failures++;
    $display("unexpected at %0t: watchdog", $time);
    stop_test();
  end
  // Main sequence
  initial begin
    core_clk = 1'b0; reset = 1'b1; hsel = 1'b0; haddr = 32'h0;
    htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
    failures = 0; check_count = 0; selB = 1'b0;
    foreach (regs[i]) mdl[regs[i]] = 0;
    void'($urandom(95110));
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    foreach (regs[i]) rdc(regs[i]);
    chkb(timerOutputPin, 1'b0);
    done("reset");
    // Register access, read-only counter, unmapped place
    wr(OFS_MATCH, 32'($urandom_range(0, 255)));
    rdc(OFS_MATCH);
    wr(OFS_MATCH, 32'hFF);
    rdc(OFS_MATCH);
    wr(CSA, 32'h07);
    rdc(CSA);
    wr(OFS_COUNT, 32'h55);
    wr(32'h0000_0020, 32'h5A);
    rdc(OFS_COUNT);
    rdc(32'h0000_0020);
    done("registers");
    // Toggle period per internal clock code, level bit on
    wr(OFS_MODE, 32'h01);
    wr(OFS_MODE, 32'h03);
    for (int k = 2; k < 8; k++) begin
      m = (k == 7) ? 0 : $urandom_range(1, 3);
      wr(OFS_MODE, 32'h03); // Stop before reselect
      wr(CSA, 32'(k));
      wr(OFS_MATCH, 32'(m));
      wr(OFS_MODE, 32'h83);
      gap(c);
      gap(c);
      chk(32'(c), 32'((m + 1) << lg[k]));
    end
    // Interrupt masked, unmasked, cleared by status read
    chkb(matchInterrupt, 1'b0);
    wr(OFS_MASK, 32'h01);
    repeat (2) @(posedge core_clk);
    chkb(matchInterrupt, 1'b1);
    mdl[OFS_STATUS] = 1;
    rdc(OFS_STATUS);
    repeat (2) @(posedge core_clk);
    chkb(matchInterrupt, 1'b0);
    mdl[OFS_STATUS] = 0;
    rdc(OFS_STATUS);
    done("clock codes");
    // Second instance: its own middle and slowest codes
    selB <= 1'b1;
    for (int k = 4; k < 8; k += 3) begin
      m = (k == 7) ? 0 : $urandom_range(1, 3);
      wr(OFS_MODE, 32'h03);
      wr(CSB, 32'(k));
      wr(OFS_MATCH, 32'(m));
      wr(OFS_MODE, 32'h83);
      gap(c);
      gap(c);
      n = (k == 7) ? LOG_B_SLOW : LOG_B_MID;
      chk(32'(c), 32'((m + 1) << n));
    end
    wr(OFS_MODE, 32'h00);
    selB <= 1'b0;
    done("second instance");
    // External edges, rising then falling with clear on match
    for (int e = 0; e < 2; e++) begin
      m = e ? 3 : 255;
      n = $urandom_range(1, 20);
      wr(OFS_MODE, 32'h03);
      mdl[OFS_COUNT] = 0;
      rdc(OFS_COUNT);
      wr(CSA, e ? 32'(CS_FALL) : 32'(CS_RISE));
      wr(OFS_MATCH, 32'(m));
      wr(OFS_MODE, 32'h83);
      i_pin.pulse(n);
      repeat (8) @(posedge core_clk);
      mdl[OFS_COUNT] = n % (m + 1);
      rdc(OFS_COUNT);
    end
    done("event input");
    // PWM duty, polarity, overflow interrupt, stop
    wr(OFS_MODE, 32'h03);
    wr(CSA, 32'(CS_FX));
    m = $urandom_range(16, 200);
    wr(OFS_MATCH, 32'(m));
    wr(OFS_MODE, 32'h01);
    wr(OFS_MODE, 32'h41);
    wr(OFS_MASK, 32'h02);
    wr(OFS_MODE, 32'hC1);
    repeat (300) @(posedge core_clk);
    hi(c);
    chkb(c == m || c == m + 1, 1'b1);
    chkb(matchInterrupt, 1'b1);
    wr(OFS_MODE, 32'hC3);
    hi(c);
    chkb(c == 256 - m || c == 255 - m, 1'b1);
    wr(OFS_MODE, 32'h43);
    hi(c);
    chk(32'(c), 32'd256);
    mdl[OFS_COUNT] = 0;
    rdc(OFS_COUNT);
    done("pwm");
    // Flip-flop strobes and output enable in clear mode
    wr(OFS_MODE, 32'h03);
    wr(OFS_MODE, 32'h01);
    wr(OFS_MODE, 32'h05);
    repeat (2) @(posedge core_clk);
    chkb(timerOutputPin, 1'b0);
    wr(OFS_MODE, 32'h09);
    repeat (2) @(posedge core_clk);
    chkb(timerOutputPin, 1'b1);
    wr(OFS_MODE, 32'h00);
    repeat (2) @(posedge core_clk);
    chkb(timerOutputPin, 1'b0);
    rdc(OFS_MODE);
    done("output");
    stop_test();
  end
endmodule // eight_bit_event_timer_bench
`default_nettype wire
